//--- rtl/option_cfg_pkg.sv
package option_cfg_pkg;

  // ****************************************
  // Stored byte values
  // ****************************************
  localparam logic [7:0] CFG0_RESET = 8'hfe; // Shipped value of config_byte_zero
  localparam logic [7:0] CFG1_RESET = 8'hef; // Shipped value of config_byte_one
  localparam logic [7:0] ERASED_BYTE = 8'hff; // Blank storage reads as all ones

  // ****************************************
  // Byte selection on the programming port
  // ****************************************
  localparam logic CFG_SEL_ZERO = 1'b0;
  localparam logic CFG_SEL_ONE = 1'b1;

  // ****************************************
  // Field positions, config_byte_zero
  // ****************************************
  localparam int RSVD0_MSB = 7;
  localparam int RSVD0_LSB = 2;
  localparam int IRQ_MAP_BIT = 1;
  localparam int LOCK_BIT = 0;

  // ****************************************
  // Field positions, config_byte_one
  // ****************************************
  localparam int CF_OFF_BIT = 7;
  localparam int OSC_MSB = 6;
  localparam int OSC_LSB = 4;
  localparam int SUP_MSB = 3;
  localparam int SUP_LSB = 2;
  localparam int WATCHDOG_HALT_RESET_BIT = 1;
  localparam int WDG_SOFT_BIT = 0;

  // ****************************************
  // Field encodings
  // ****************************************
  localparam logic [2:0] OSC_EXT_CLOCK = 3'h7;
  localparam logic [2:0] OSC_INT_RC = 3'h6;
  localparam logic [1:0] OSC_EXT_RC_HI = 2'h2; // Upper two bits only, low bit ignored
  localparam logic [2:0] OSC_LP = 3'h3;
  localparam logic [2:0] OSC_MP = 3'h2;
  localparam logic [2:0] OSC_MS = 3'h1;
  localparam logic [1:0] SUP_OFF = 2'h3;
  localparam logic [1:0] SUP_HIGH = 2'h2;
  localparam logic [1:0] SUP_MED = 2'h1;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [6:0] {
    CLK_EXT_CLOCK = 7'h40,
    CLK_INT_RC = 7'h20,
    CLK_EXT_RC = 7'h10,
    CLK_LOW_POWER_RESONATOR = 7'h08,
    CLK_MEDIUM_POWER_RESONATOR = 7'h04,
    CLK_MEDIUM_SPEED_RESONATOR = 7'h02,
    CLK_HIGH_SPEED_RESONATOR = 7'h01
  } clk_src_t;

  typedef enum logic [3:0] {
    SUPPLY_OFF = 4'h8,
    SUPPLY_HIGH = 4'h4,
    SUPPLY_MED = 4'h2,
    SUPPLY_LOW = 4'h1
  } supply_sel_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h1,
    ST_ERASE = 2'h2
  } state_t;

endpackage

//--- rtl/option_field_decode.sv
`timescale 1ns/1ps
module option_field_decode
  import option_cfg_pkg::*;
(
  input wire logic [7:0] cfg0_i, // config_byte_zero
  input wire logic [7:0] cfg1_i, // config_byte_one
  output logic irq_port_c_on_b_o, // Port C served by vector b
  output logic readout_lock_o, // External readout blocked
  output logic clock_filter_en_o, // Clock filter active
  output clk_src_t clock_source_o, // One-hot main clock source
  output supply_sel_t supply_threshold_o, // One-hot detector setting
  output logic watchdog_halt_reset_o, // Halt with watchdog resets
  output logic watchdog_hw_en_o // Watchdog forced on
);

  // ****************************************
  // Field decode
  // ****************************************

  // Single bit fields, reserved bits ignored
  always_comb begin
    irq_port_c_on_b_o = cfg0_i[IRQ_MAP_BIT];
    readout_lock_o = cfg0_i[LOCK_BIT];
    clock_filter_en_o = ~cfg1_i[CF_OFF_BIT];
    watchdog_halt_reset_o = cfg1_i[WATCHDOG_HALT_RESET_BIT];
    watchdog_hw_en_o = ~cfg1_i[WDG_SOFT_BIT];
  end

  // Oscillator field; 10x covers both low-bit values
  always_comb begin
    if (cfg1_i[OSC_MSB -: 2] == OSC_EXT_RC_HI) begin
      clock_source_o = CLK_EXT_RC;
    end else begin
      case (cfg1_i[OSC_MSB:OSC_LSB])
        OSC_EXT_CLOCK: clock_source_o = CLK_EXT_CLOCK;
        OSC_INT_RC: clock_source_o = CLK_INT_RC;
        OSC_LP: clock_source_o = CLK_LOW_POWER_RESONATOR;
        OSC_MP: clock_source_o = CLK_MEDIUM_POWER_RESONATOR;
        OSC_MS: clock_source_o = CLK_MEDIUM_SPEED_RESONATOR;
        default: clock_source_o = CLK_HIGH_SPEED_RESONATOR;
      endcase
    end
  end

  // Supply detector field
  always_comb begin
    case (cfg1_i[SUP_MSB:SUP_LSB])
      SUP_OFF: supply_threshold_o = SUPPLY_OFF;
      SUP_HIGH: supply_threshold_o = SUPPLY_HIGH;
      SUP_MED: supply_threshold_o = SUPPLY_MED;
      default: supply_threshold_o = SUPPLY_LOW;
    endcase
  end

endmodule // option_field_decode

//--- rtl/option_byte_config_decoder.sv
`timescale 1ns/1ps
module option_byte_config_decoder
  import option_cfg_pkg::*;
#(
  parameter int MEM_AW = 13, // Program memory address width
  parameter int MEM_DW = 8, // Program memory data width
  parameter int MEM_WORDS = 8192, // Words wiped on erase
  parameter bit MASK_VARIANT = 1'b0, // Factory-coded part
  parameter logic [7:0] MASK_CFG0 = CFG0_RESET, // Fixed byte zero in mask part
  parameter logic [7:0] MASK_CFG1 = CFG1_RESET // Fixed byte one in mask part
) (
  input wire logic mclk_i, // System clock
  input wire logic srst_i, // Synchronous reset, high
  // Non-volatile cells, held outside
  input wire logic [7:0] nv_cfg0_i, // Stored config_byte_zero
  input wire logic [7:0] nv_cfg1_i, // Stored config_byte_one
  input wire logic nv_blank_i, // Cells never programmed
  output logic nv_we_o, // Write pulse to cells
  output logic nv_sel_o, // Byte addressed by write
  output logic [7:0] nv_wdata_o, // Byte to store
  // Programming port, only live in programming mode
  input wire logic prog_mode_i, // Device in programming mode
  input wire logic prog_rd_i, // Read request
  input wire logic prog_wr_i, // Write request
  input wire logic prog_sel_i, // Which configuration byte
  input wire logic [7:0] prog_wdata_i, // Write data
  output logic [7:0] prog_rdata_o, // Read data
  output logic prog_rvalid_o, // Read data valid pulse
  output logic prog_busy_o, // Erase in progress
  // External readout of program memory
  input wire logic ext_rd_i, // External read request
  output logic ext_rd_grant_o, // Read allowed pulse
  output logic ext_rd_denied_o, // Read blocked pulse
  // Program memory wipe
  input wire logic [MEM_DW-1:0] mem_latch_data_i, // Currently latched values
  output logic mem_erase_we_o, // Wipe write strobe
  output logic [MEM_AW-1:0] mem_erase_addr_o, // Wipe address
  output logic [MEM_DW-1:0] mem_erase_data_o, // Wipe data
  // Decoded configuration
  output logic irq_port_c_on_b_o, // Port C on vector b
  output logic readout_lock_o, // Readout protection active
  output logic clock_filter_en_o, // Clock filter enabled
  output clk_src_t clock_source_o, // Main clock source
  output supply_sel_t supply_threshold_o, // Supply detector setting
  output logic watchdog_halt_reset_o, // Halt resets with watchdog on
  output logic watchdog_hw_en_o, // Watchdog forced on
  // Watchdog and halt
  input wire logic wdg_soft_en_i, // Software watchdog enable
  input wire logic halt_entry_i, // Halt instruction executed
  output logic watchdog_active_o, // Watchdog running
  output logic halt_reset_o // Reset request pulse
);

  // ****************************************
  // State
  // ****************************************

  typedef struct packed {
    // Sequencing and reset-time copies
    state_t fsm;
    logic busy;
    logic [7:0] shadow0;
    logic [7:0] shadow1;
    // Cell write port
    logic nv_we;
    logic nv_sel;
    logic [7:0] nv_wdata;
    // Programming read port
    logic [7:0] prog_rdata;
    logic prog_rvalid;
    // External readout answers
    logic ext_grant;
    logic ext_denied;
    // Wipe port
    logic erase_we;
    logic [MEM_AW-1:0] erase_addr;
    logic [MEM_DW-1:0] erase_data;
    // Decoded configuration
    logic irq_c_on_b;
    logic lock;
    logic filter_en;
    clk_src_t clk_src;
    supply_sel_t supply;
    logic watchdog_halt_reset_rst;
    logic wdg_hw_en;
    // Watchdog
    logic wdg_active;
    logic halt_reset;
  } state_s_t;

  // Final word of the wipe walk
  localparam logic [MEM_AW-1:0] LAST_ADDR = MEM_AW'(MEM_WORDS - 1);

  // Registered state and its next value
  state_s_t st;
  state_s_t next_st;

  // Bytes after blank and mask substitution
  logic [7:0] src0;
  logic [7:0] src1;
  logic [7:0] stored0;
  logic [7:0] stored1;

  // Field decoder results
  logic dec_irq_c_on_b;
  logic dec_lock;
  logic dec_filter_en;
  clk_src_t dec_clk_src;
  supply_sel_t dec_supply;
  logic dec_watchdog_halt_reset_rst;
  logic dec_wdg_hw_en;

  // Write qualifiers
  logic wr_ok;
  logic lock_clear;

  // ****************************************
  // Byte sources
  // ****************************************

  // Blank cells read as all ones
  always_comb begin
    stored0 = nv_blank_i ? ERASED_BYTE : nv_cfg0_i;
    stored1 = nv_blank_i ? ERASED_BYTE : nv_cfg1_i;
  end

  // Mask parts ignore the cells entirely
  always_comb begin
    src0 = MASK_VARIANT ? MASK_CFG0 : stored0;
    src1 = MASK_VARIANT ? MASK_CFG1 : stored1;
  end

  // Decode always works from the reset-time copies
  option_field_decode u_decode (
    .cfg0_i(st.shadow0),
    .cfg1_i(st.shadow1),
    .irq_port_c_on_b_o(dec_irq_c_on_b),
    .readout_lock_o(dec_lock),
    .clock_filter_en_o(dec_filter_en),
    .clock_source_o(dec_clk_src),
    .supply_threshold_o(dec_supply),
    .watchdog_halt_reset_o(dec_watchdog_halt_reset_rst),
    .watchdog_hw_en_o(dec_wdg_hw_en)
  );

  // ****************************************
  // Programming access qualifiers
  // ****************************************

  // No path without programming mode; mask parts have nothing to write
  always_comb begin
    wr_ok = prog_mode_i & prog_wr_i & ~MASK_VARIANT & (st.fsm == ST_IDLE);
    lock_clear = wr_ok & (prog_sel_i == CFG_SEL_ZERO) & stored0[LOCK_BIT]
                 & ~prog_wdata_i[LOCK_BIT];
  end

  // ****************************************
  // Next state
  // ****************************************

  always_comb begin
    // Pulses default low, everything else holds
    next_st = st;
    next_st.nv_we = 1'b0;
    next_st.prog_rvalid = 1'b0;
    next_st.ext_grant = 1'b0;
    next_st.ext_denied = 1'b0;
    next_st.erase_we = 1'b0;
    next_st.halt_reset = 1'b0;

    // Reads of the bytes, gated by programming mode only, also in mask parts and during a wipe
    if (prog_mode_i & prog_rd_i) begin
      next_st.prog_rvalid = 1'b1;
      next_st.prog_rdata = (prog_sel_i == CFG_SEL_ONE) ? src1 : src0;
    end

    // Byte write; reserved bits are stored as given
    if (wr_ok) begin
      next_st.nv_we = 1'b1;
      next_st.nv_sel = prog_sel_i;
      next_st.nv_wdata = prog_wdata_i;
    end

    // External readout; a wipe in flight also blocks it
    if (ext_rd_i) begin
      if (st.lock | (st.fsm == ST_ERASE)) begin
        next_st.ext_denied = 1'b1;
      end else begin
        next_st.ext_grant = 1'b1;
      end
    end

    // Wipe walks every word once, one word a cycle
    case (st.fsm)
      ST_IDLE: begin
        // Stored bit, not the shadow, so a second clear cannot restart a wipe
        if (lock_clear) begin
          next_st.fsm = ST_ERASE;
          next_st.erase_addr = '0;
        end
      end
      ST_ERASE: begin
        next_st.erase_we = 1'b1;
        next_st.erase_data = mem_latch_data_i;
        if (st.erase_we) begin
          if (st.erase_addr == LAST_ADDR) begin
            next_st.fsm = ST_IDLE;
            next_st.erase_we = 1'b0;
          end else begin
            next_st.erase_addr = st.erase_addr + 1'b1;
          end
        end
      end
      default: begin
        next_st.fsm = ST_IDLE;
      end
    endcase

    // Busy mirrors the wipe state so the port comes from a flop
    next_st.busy = (next_st.fsm == ST_ERASE);

    // Decoded outputs only follow the shadows, which move only at reset
    next_st.irq_c_on_b = dec_irq_c_on_b;
    next_st.lock = dec_lock;
    next_st.filter_en = dec_filter_en;
    next_st.clk_src = dec_clk_src;
    next_st.supply = dec_supply;
    next_st.watchdog_halt_reset_rst = dec_watchdog_halt_reset_rst;
    next_st.wdg_hw_en = dec_wdg_hw_en;

    // Hardware watchdog cannot be turned off by software
    next_st.wdg_active = st.wdg_hw_en | wdg_soft_en_i | st.wdg_active;

    // Halt only requests a reset while the watchdog runs
    next_st.halt_reset = halt_entry_i & st.wdg_active & st.watchdog_halt_reset_rst;

    // Reset catches the bytes; decode settles one edge after release
    if (srst_i) begin
      next_st = '0;
      next_st.fsm = ST_IDLE;
      next_st.shadow0 = src0;
      next_st.shadow1 = src1;
      next_st.clk_src = CLK_HIGH_SPEED_RESONATOR;
      next_st.supply = SUPPLY_LOW;
      next_st.lock = 1'b1; // Safe side until decode is valid
    end
  end

  // Single state register
  always_ff @(posedge mclk_i) begin
    st <= next_st;
  end

  // ****************************************
  // Outputs, all straight from flops
  // ****************************************

  // Cell write port
  assign nv_we_o = st.nv_we;
  assign nv_sel_o = st.nv_sel;
  assign nv_wdata_o = st.nv_wdata;

  // Programming read port and busy
  assign prog_rdata_o = st.prog_rdata;
  assign prog_rvalid_o = st.prog_rvalid;
  assign prog_busy_o = st.busy;

  // Readout answers
  assign ext_rd_grant_o = st.ext_grant;
  assign ext_rd_denied_o = st.ext_denied;

  // Wipe port
  assign mem_erase_we_o = st.erase_we;
  assign mem_erase_addr_o = st.erase_addr;
  assign mem_erase_data_o = st.erase_data;

  // Decoded configuration
  assign irq_port_c_on_b_o = st.irq_c_on_b;
  assign readout_lock_o = st.lock;
  assign clock_filter_en_o = st.filter_en;
  assign clock_source_o = st.clk_src;
  assign supply_threshold_o = st.supply;
  assign watchdog_halt_reset_o = st.watchdog_halt_reset_rst;
  assign watchdog_hw_en_o = st.wdg_hw_en;

  // Watchdog
  assign watchdog_active_o = st.wdg_active;
  assign halt_reset_o = st.halt_reset;

endmodule // option_byte_config_decoder

//--- testbench/nv_cell_model.sv
`timescale 1ns/1ps
module nv_cell_model
  import option_cfg_pkg::*;
(
  input wire logic mclk_i, // Clock
  input wire logic we_i, // Store pulse
  input wire logic sel_i, // Byte select
  input wire logic [7:0] wdata_i, // Byte to store
  output logic [7:0] cfg0_o, // Cell byte zero
  output logic [7:0] cfg1_o, // Cell byte one
  output logic blank_o // Never programmed
);
  // Fresh cells read as all ones
  initial begin
    cfg0_o = ERASED_BYTE;
    cfg1_o = ERASED_BYTE;
    blank_o = 1'b1;
  end
  // Store only on the block's own strobe, never from the CPU side
  always @(posedge mclk_i) begin
    if (we_i) begin
      blank_o <= 1'b0;
      if (sel_i == CFG_SEL_ZERO) cfg0_o <= wdata_i;
      else cfg1_o <= wdata_i;
    end
  end
endmodule // nv_cell_model

//--- testbench/option_byte_config_decoder_sva.sv
`timescale 1ns/1ps
module option_byte_config_decoder_sva
  import option_cfg_pkg::*;
#(
  parameter bit MASK_VARIANT = 1'b0,
  parameter logic [7:0] MASK_CFG0 = CFG0_RESET,
  parameter logic [7:0] MASK_CFG1 = CFG1_RESET
) (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic [7:0] nv_cfg0_i,
  input wire logic [7:0] nv_cfg1_i,
  input wire logic nv_blank_i,
  input wire logic nv_we_o,
  input wire logic prog_mode_i,
  input wire logic prog_rd_i,
  input wire logic prog_wr_i,
  input wire logic prog_sel_i,
  input wire logic [7:0] prog_wdata_i,
  input wire logic prog_rvalid_o,
  input wire logic prog_busy_o,
  input wire logic ext_rd_i,
  input wire logic ext_rd_grant_o,
  input wire logic ext_rd_denied_o,
  input wire logic mem_erase_we_o,
  input wire logic irq_port_c_on_b_o,
  input wire logic readout_lock_o,
  input wire logic clock_filter_en_o,
  input wire logic watchdog_halt_reset_o,
  input wire logic watchdog_hw_en_o,
  input wire logic halt_entry_i,
  input wire logic watchdog_active_o,
  input wire logic halt_reset_o
);
  // ****************************************
  // Copy of the bytes seen during reset
  // ****************************************
  logic [7:0] sh0;
  logic [7:0] sh1;
  logic live;
  // Decode is only trusted one edge after release
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      sh0 <= MASK_VARIANT ? MASK_CFG0 : (nv_blank_i ? ERASED_BYTE : nv_cfg0_i);
      sh1 <= MASK_VARIANT ? MASK_CFG1 : (nv_blank_i ? ERASED_BYTE : nv_cfg1_i);
    end
    live <= !srst_i;
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  // ****************************************
  // Properties
  // ****************************************
  property p_rd_resp;
    prog_mode_i && prog_rd_i |=> prog_rvalid_o;
  endproperty
  a_rd_resp: assert property (p_rd_resp) else $error("read not answered");
  property p_no_mode;
    !prog_mode_i |=> !prog_rvalid_o && !nv_we_o;
  endproperty
  a_no_mode: assert property (p_no_mode) else $error("access outside prog mode");
  property p_deny;
    ext_rd_i && readout_lock_o |=> ext_rd_denied_o && !ext_rd_grant_o;
  endproperty
  a_deny: assert property (p_deny) else $error("locked read not denied");
  property p_grant;
    live && ext_rd_i && !readout_lock_o && !prog_busy_o |=> ext_rd_grant_o && !ext_rd_denied_o;
  endproperty
  a_grant: assert property (p_grant) else $error("open read not granted");
  property p_dec0;
    live |-> irq_port_c_on_b_o == sh0[IRQ_MAP_BIT] && readout_lock_o == sh0[LOCK_BIT];
  endproperty
  a_dec0: assert property (p_dec0) else $error("byte zero decode wrong");
  property p_dec1;
    live |-> clock_filter_en_o == !sh1[CF_OFF_BIT] && watchdog_hw_en_o == !sh1[WDG_SOFT_BIT]
      && watchdog_halt_reset_o == sh1[WATCHDOG_HALT_RESET_BIT];
  endproperty
  a_dec1: assert property (p_dec1) else $error("byte one decode wrong");
  property p_halt;
    halt_entry_i && watchdog_active_o |=> halt_reset_o == $past(watchdog_halt_reset_o);
  endproperty
  a_halt: assert property (p_halt) else $error("halt reset wrong");
  property p_hold;
    live |=> $stable(readout_lock_o) && $stable(irq_port_c_on_b_o);
  endproperty
  a_hold: assert property (p_hold) else $error("decode moved before reset");
  sequence s_erase_req;
    !MASK_VARIANT && prog_mode_i && prog_wr_i && prog_sel_i == CFG_SEL_ZERO && !prog_wdata_i[LOCK_BIT]
      && (nv_blank_i || nv_cfg0_i[LOCK_BIT]) && !prog_busy_o;
  endsequence
  property p_erase;
    s_erase_req |=> prog_busy_o ##1 mem_erase_we_o;
  endproperty
  a_erase: assert property (p_erase) else $error("erase did not start");
  property p_mask_nowr;
    MASK_VARIANT |-> !nv_we_o && !prog_busy_o;
  endproperty
  a_mask_nowr: assert property (p_mask_nowr) else $error("mask part wrote cells");
  c_erase: cover property (s_erase_req);
  c_grant: cover property (ext_rd_grant_o);
  c_halt: cover property (halt_reset_o);
endmodule // option_byte_config_decoder_sva

bind option_byte_config_decoder option_byte_config_decoder_sva #(.MASK_VARIANT(MASK_VARIANT),
  .MASK_CFG0(MASK_CFG0), .MASK_CFG1(MASK_CFG1)) i_sva (
  .mclk_i(mclk_i), .srst_i(srst_i), .nv_cfg0_i(nv_cfg0_i), .nv_cfg1_i(nv_cfg1_i),
  .nv_blank_i(nv_blank_i), .nv_we_o(nv_we_o), .prog_mode_i(prog_mode_i), .prog_rd_i(prog_rd_i),
  .prog_wr_i(prog_wr_i), .prog_sel_i(prog_sel_i), .prog_wdata_i(prog_wdata_i),
  .prog_rvalid_o(prog_rvalid_o), .prog_busy_o(prog_busy_o), .ext_rd_i(ext_rd_i),
  .ext_rd_grant_o(ext_rd_grant_o), .ext_rd_denied_o(ext_rd_denied_o),
  .mem_erase_we_o(mem_erase_we_o), .irq_port_c_on_b_o(irq_port_c_on_b_o),
  .readout_lock_o(readout_lock_o), .clock_filter_en_o(clock_filter_en_o),
  .watchdog_halt_reset_o(watchdog_halt_reset_o), .watchdog_hw_en_o(watchdog_hw_en_o),
  .halt_entry_i(halt_entry_i), .watchdog_active_o(watchdog_active_o),
  .halt_reset_o(halt_reset_o));

//--- testbench/option_byte_config_decoder_tb.sv
`timescale 1ns/1ps
module option_byte_config_decoder_tb;
  import option_cfg_pkg::*;
  logic mclk_i, srst_i, nv_blank, nv_we, nv_sel, prog_mode, prog_rd, prog_wr, prog_sel;
  logic prog_rvalid, prog_busy, ext_rd, ext_grant, ext_denied, erase_we, irq_cb, lock, cf_en;
  logic watchdog_halt_reset, wdg_hw, wdg_soft_en, halt_entry, wdg_act, halt_rst;
  logic [7:0] nv_cfg0, nv_cfg1, nv_wdata, prog_wdata, prog_rdata, latch_data, erase_data;
  logic [3:0] erase_addr;
  clk_src_t csrc;
  supply_sel_t sup;
  // Factory-coded twin: byte zero maps C to vector a, locked; byte one picks LP, detector off
  localparam logic [7:0] MASK_B0 = 8'hfd;
  localparam logic [7:0] MASK_B1 = 8'h3e;
  logic m_we, m_busy, m_denied, m_irq, m_lock, m_cf, m_hw;
  logic [7:0] m_rdata;
  clk_src_t m_csrc;
  supply_sel_t m_sup;
  int fail_count = 0;
  int n_checks = 0;
  clk_src_t osc_tab[8] = '{CLK_HIGH_SPEED_RESONATOR, CLK_MEDIUM_SPEED_RESONATOR,
    CLK_MEDIUM_POWER_RESONATOR, CLK_LOW_POWER_RESONATOR, CLK_EXT_RC, CLK_EXT_RC, CLK_INT_RC,
    CLK_EXT_CLOCK};
  supply_sel_t sup_tab[4] = '{SUPPLY_LOW, SUPPLY_MED, SUPPLY_HIGH, SUPPLY_OFF};

  // Short wipe so the erase walk stays brief
  option_byte_config_decoder #(.MEM_AW(4), .MEM_WORDS(16)) i_dut (
    .mclk_i(mclk_i), .srst_i(srst_i), .nv_cfg0_i(nv_cfg0), .nv_cfg1_i(nv_cfg1),
    .nv_blank_i(nv_blank), .nv_we_o(nv_we), .nv_sel_o(nv_sel), .nv_wdata_o(nv_wdata),
    .prog_mode_i(prog_mode), .prog_rd_i(prog_rd), .prog_wr_i(prog_wr), .prog_sel_i(prog_sel),
    .prog_wdata_i(prog_wdata), .prog_rdata_o(prog_rdata), .prog_rvalid_o(prog_rvalid),
    .prog_busy_o(prog_busy), .ext_rd_i(ext_rd), .ext_rd_grant_o(ext_grant),
    .ext_rd_denied_o(ext_denied), .mem_latch_data_i(latch_data), .mem_erase_we_o(erase_we),
    .mem_erase_addr_o(erase_addr), .mem_erase_data_o(erase_data), .irq_port_c_on_b_o(irq_cb),
    .readout_lock_o(lock), .clock_filter_en_o(cf_en), .clock_source_o(csrc),
    .supply_threshold_o(sup), .watchdog_halt_reset_o(watchdog_halt_reset), .watchdog_hw_en_o(wdg_hw),
    .wdg_soft_en_i(wdg_soft_en), .halt_entry_i(halt_entry), .watchdog_active_o(wdg_act),
    .halt_reset_o(halt_rst));
  // Same cells and port, but the fixed bytes must win and writes must die
  option_byte_config_decoder #(.MEM_AW(4), .MEM_WORDS(16), .MASK_VARIANT(1'b1),
    .MASK_CFG0(MASK_B0), .MASK_CFG1(MASK_B1)) i_dut_mask (
    .mclk_i(mclk_i), .srst_i(srst_i), .nv_cfg0_i(nv_cfg0), .nv_cfg1_i(nv_cfg1),
    .nv_blank_i(nv_blank), .nv_we_o(m_we), .nv_sel_o(), .nv_wdata_o(),
    .prog_mode_i(prog_mode), .prog_rd_i(prog_rd), .prog_wr_i(prog_wr), .prog_sel_i(prog_sel),
    .prog_wdata_i(prog_wdata), .prog_rdata_o(m_rdata), .prog_rvalid_o(),
    .prog_busy_o(m_busy), .ext_rd_i(ext_rd), .ext_rd_grant_o(),
    .ext_rd_denied_o(m_denied), .mem_latch_data_i(latch_data), .mem_erase_we_o(),
    .mem_erase_addr_o(), .mem_erase_data_o(), .irq_port_c_on_b_o(m_irq),
    .readout_lock_o(m_lock), .clock_filter_en_o(m_cf), .clock_source_o(m_csrc),
    .supply_threshold_o(m_sup), .watchdog_halt_reset_o(), .watchdog_hw_en_o(m_hw),
    .wdg_soft_en_i(wdg_soft_en), .halt_entry_i(halt_entry), .watchdog_active_o(),
    .halt_reset_o());
  nv_cell_model i_nv (.mclk_i(mclk_i), .we_i(nv_we), .sel_i(nv_sel), .wdata_i(nv_wdata),
    .cfg0_o(nv_cfg0), .cfg1_o(nv_cfg1), .blank_o(nv_blank));

  // ****************************************
  // Helpers
  // ****************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Reset, then one edge so the decode is settled
  task automatic do_reset();
    srst_i = 1'b1;
    repeat (2) @(negedge mclk_i);
    srst_i = 1'b0;
    @(negedge mclk_i);
  endtask
  task automatic rd(input logic sel, input logic [7:0] exp);
    prog_rd = 1'b1;
    prog_sel = sel;
    @(negedge mclk_i);
    prog_rd = 1'b0;
    check(prog_rvalid, 1'b1);
    check(prog_rdata, exp);
    // Idle edge so a following call never re-raises the strobe in this step
    @(negedge mclk_i);
  endtask
  // Extra edge lets the cell model store before anything else
  task automatic wr(input logic m, input logic sel, input logic [7:0] d);
    prog_mode = m;
    prog_wr = 1'b1;
    prog_sel = sel;
    prog_wdata = d;
    @(negedge mclk_i);
    prog_wr = 1'b0;
    prog_mode = 1'b1;
    check(nv_we, m);
    check(m_we, 1'b0);
    @(negedge mclk_i);
  endtask
  task automatic exrd(input logic g);
    ext_rd = 1'b1;
    @(negedge mclk_i);
    ext_rd = 1'b0;
    check(ext_grant, g);
    check(ext_denied, !g);
  endtask

  initial begin
    mclk_i = 1'b0;
    forever #50 mclk_i = ~mclk_i;
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    int n;
    logic [2:0] f;
    logic [7:0] v;
    {prog_rd, prog_wr, prog_sel, prog_wdata, ext_rd, wdg_soft_en, halt_entry} = '0;
    prog_mode = 1'b1;
    latch_data = 8'h5a;
    do_reset();
    // Blank cells: all ones, readout locked
    rd(CFG_SEL_ZERO, 8'hff);
    check(m_rdata, MASK_B0);
    rd(CFG_SEL_ONE, 8'hff);
    check(m_rdata, MASK_B1);
    exrd(1'b0);
    check(m_denied, 1'b1);
    // Mask part decodes its fixed bytes, not the blank cells
    check(m_irq, 1'b0);
    check(m_lock, 1'b1);
    check(m_cf, 1'b1);
    check(8'(m_csrc), 8'(CLK_LOW_POWER_RESONATOR));
    check(8'(m_sup), 8'(SUPPLY_OFF));
    check(m_hw, 1'b1);
    // Outside programming mode nothing reaches the cells
    wr(1'b0, CFG_SEL_ZERO, 8'hfc);
    rd(CFG_SEL_ZERO, 8'hff);
    // Reserved bits written as ones, lock bit cleared starts a wipe
    wr(1'b1, CFG_SEL_ZERO, 8'hfe);
    check(m_busy, 1'b0);
    n = 0;
    for (int k = 0; k < 40 && prog_busy !== 1'b0; k++) begin
      if (erase_we === 1'b1) begin
        check(8'(erase_addr), 8'(n));
        check(erase_data, latch_data);
        n++;
      end
      @(negedge mclk_i);
    end
    check(prog_busy, 1'b0);
    if (prog_busy !== 1'b0) finish_test();
    check(8'(n), 8'd16);
    check(lock, 1'b1);
    do_reset();
    check(lock, 1'b0);
    check(irq_cb, 1'b1);
    check(m_irq, 1'b0);
    exrd(1'b1);
    check(m_denied, 1'b1);
    rd(CFG_SEL_ZERO, 8'hfe);
    // Setting the lock bit again must not wipe
    wr(1'b1, CFG_SEL_ZERO, 8'hfd);
    check(prog_busy, 1'b0);
    do_reset();
    check(irq_cb, 1'b0);
    check(lock, 1'b1);
    // Every oscillator code, each supply code, both watchdog modes
    for (int i = 0; i < 8; i++) begin
      f = 3'(i);
      v = {f[0], f, f[1:0], f[1], f[0]};
      wr(1'b1, CFG_SEL_ONE, v);
      do_reset();
      rd(CFG_SEL_ONE, v);
      check(cf_en, !f[0]);
      check(8'(csrc), 8'(osc_tab[f]));
      check(8'(sup), 8'(sup_tab[f[1:0]]));
      check(wdg_hw, !f[0]);
      check(wdg_act, !f[0]);
      wdg_soft_en = 1'b1;
      @(negedge mclk_i);
      wdg_soft_en = 1'b0;
      check(wdg_act, 1'b1);
      halt_entry = 1'b1;
      @(negedge mclk_i);
      halt_entry = 1'b0;
      check(halt_rst, f[1]);
    end
    finish_test();
  end
endmodule // option_byte_config_decoder_tb
